// ---- rtl/pov_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module pov_dev
   import pov_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   pov_if.dev link,
   output logic divider_reset_override,
   output logic pll_lock,
   output logic [3:0] pll_state
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] index;
      logic [7:0] ovr_ctrl;
      logic [7:0] fsm_ovr;
      logic ack;
      logic [7:0] rdata;
      logic div_ovr;
      logic lock;
      logic [3:0] st;
   } pov_dev_s;
   pov_dev_s s_q, s_d;
   logic [3:0] ctl_state;
   logic ctl_locked;
   logic [7:0] page_rd;
   logic page_hit;

   // Powerdown low holds the controller in reset, as the pin does.
   pov_pll_ctl i_pov_pll_ctl (
      .pclk(pclk),
      .presetn(presetn),
      .run(link.powerdown_n_pin),
      .fsm_override_enable(s_q.fsm_ovr[POV_BIT_FSM_OVR_EN]),
      .forced_state(s_q.fsm_ovr[POV_FSM_STATE_MSB:0]),
      .state(ctl_state),
      .locked(ctl_locked)
   );

   // ------------------------------------------------------------
   // Register access
   // ------------------------------------------------------------
   always_comb begin
      page_hit = (s_q.page == POV_PAGE_INPUT);
      page_rd = 8'h00;
      if (page_hit && s_q.index == POV_OFS_OVERRIDE_CTRL) begin
         page_rd = s_q.ovr_ctrl;
      end else if (page_hit && s_q.index == POV_OFS_FSM_OVERRIDE) begin
         page_rd = s_q.fsm_ovr;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.ack = 1'b0;
      if (link.req && !s_q.ack) begin
         s_d.ack = 1'b1;
         s_d.rdata = 8'h00;
         unique case (link.addr)
            POV_SER_PAGE: begin
               if (link.wr) s_d.page = link.wdata;
               s_d.rdata = s_q.page;
            end
            POV_SER_INDEX: begin
               if (link.wr) s_d.index = link.wdata;
               s_d.rdata = s_q.index;
            end
            POV_SER_DATA: begin
               s_d.rdata = page_rd;
               // Index is left alone so repeated writes hit one register.
               if (link.wr && page_hit && s_q.index == POV_OFS_OVERRIDE_CTRL) begin
                  s_d.ovr_ctrl = link.wdata & POV_OVERRIDE_CTRL_MASK;
               end
               if (link.wr && page_hit && s_q.index == POV_OFS_FSM_OVERRIDE) begin
                  s_d.fsm_ovr = link.wdata & POV_FSM_OVERRIDE_MASK;
               end
            end
            default: s_d.rdata = 8'h00;
         endcase
      end
      s_d.div_ovr = s_q.ovr_ctrl[POV_BIT_DIV_RST_OVR];
      s_d.lock = ctl_locked && !s_q.ovr_ctrl[POV_BIT_LOCK_FORCE];
      s_d.st = ctl_state;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.ovr_ctrl <= POV_OVERRIDE_CTRL_RST;
         s_q.fsm_ovr <= POV_FSM_OVERRIDE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.ack = s_q.ack;
   assign link.rdata = s_q.rdata;
   assign divider_reset_override = s_q.div_ovr;
   assign pll_lock = s_q.lock;
   assign pll_state = s_q.st;
endmodule : pov_dev
`default_nettype wire

// ---- rtl/pov_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module pov_host
   import pov_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   pov_if.host link
);
   typedef enum logic [2:0] {
      IDLE = 3'b001,
      REQ = 3'b010,
      WAIT = 3'b100
   } pov_hst_e;
   typedef struct packed {
      pov_hst_e st;
      logic pwr;
      logic seq;
      logic [3:0] step;
      logic req;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic ready;
      logic err;
      logic [31:0] prdata;
   } pov_hst_s;
   pov_hst_s s_q, s_d;
   logic [15:0] step_op;
   logic acc;

   // ------------------------------------------------------------
   // Power-up write sequence
   // ------------------------------------------------------------
   always_comb begin
      unique case (s_q.step)
         4'd0: step_op = {POV_SER_PAGE, POV_PAGE_INPUT};
         4'd1: step_op = {POV_SER_INDEX, POV_OFS_FSM_OVERRIDE};
         4'd2: step_op = {POV_SER_DATA, POV_INIT_FSM_DATA};
         4'd3: step_op = {POV_SER_INDEX, POV_OFS_OVERRIDE_CTRL};
         4'd4, 4'd5, 4'd6, 4'd7: step_op = {POV_SER_DATA, POV_INIT_LOCK_DATA};
         4'd8: step_op = {POV_SER_DATA, POV_INIT_RELEASE};
         4'd9: step_op = {POV_SER_INDEX, POV_OFS_FSM_OVERRIDE};
         default: step_op = {POV_SER_DATA, POV_INIT_RELEASE};
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.ready = 1'b0;
      s_d.err = 1'b0;
      acc = psel && !penable;
      // One-cycle-late answer: setup seen, answer ready during access.
      if (acc) begin
         s_d.ready = 1'b1;
         s_d.prdata = 32'h0;
         unique case (paddr)
            POV_APB_CTRL: begin
               // Powerdown pin only rises when software says supplies settled.
               if (pwrite) s_d.pwr = pwdata[POV_CTRL_PWRUP];
               if (pwrite && pwdata[POV_CTRL_START] && s_q.st == IDLE && !s_q.seq) begin
                  s_d.seq = 1'b1;
                  s_d.step = 4'd0;
               end
               s_d.prdata = {30'h0, s_q.seq, s_q.pwr};
            end
            POV_APB_STATUS: s_d.prdata = {27'h0, s_q.step, s_q.st != IDLE};
            POV_APB_ACCESS: begin
               // A GO write is dropped, not held, while the powerdown pin is low.
               if (pwrite && pwdata[POV_ACC_GO] && s_q.st == IDLE && !s_q.seq && s_q.pwr) begin
                  s_d.st = REQ;
                  s_d.wr = pwdata[POV_ACC_WRITE];
                  s_d.addr = pwdata[15:8];
                  s_d.wdata = pwdata[7:0];
               end
               s_d.prdata = {16'h0, s_q.addr, s_q.wdata};
            end
            POV_APB_RDATA: s_d.prdata = {24'h0, s_q.rdata};
            default: s_d.err = 1'b1;
         endcase
      end
      unique case (s_q.st)
         IDLE: begin
            if (s_q.seq && s_q.pwr && s_d.st == IDLE) begin
               s_d.st = REQ;
               s_d.wr = 1'b1;
               s_d.addr = step_op[15:8];
               s_d.wdata = step_op[7:0];
            end
         end
         REQ: begin
            s_d.req = 1'b1;
            s_d.st = WAIT;
         end
         WAIT: begin
            if (link.ack) begin
               s_d.req = 1'b0;
               s_d.rdata = link.rdata;
               s_d.st = IDLE;
               if (s_q.seq) begin
                  if (s_q.step == 4'(POV_INIT_STEPS - 1)) begin
                     s_d.seq = 1'b0;
                  end else begin
                     s_d.step = s_q.step + 4'd1;
                  end
               end
            end
         end
         default: s_d.st = IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.st <= IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   assign link.powerdown_n_pin = s_q.pwr;
   assign link.req = s_q.req;
   assign link.wr = s_q.wr;
   assign link.addr = s_q.addr;
   assign link.wdata = s_q.wdata;
endmodule : pov_host
`default_nettype wire

// ---- rtl/pov_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pov_if;
   logic powerdown_n_pin;
   logic req;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport dev (input powerdown_n_pin, input req, input wr, input addr, input wdata, output ack, output rdata);
   modport host (output powerdown_n_pin, output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface : pov_if
`default_nettype wire

// ---- rtl/pov_pkg.sv ----
package pov_pkg;
   // ------------------------------------------------------------
   // Serial control registers and paged override registers
   // ------------------------------------------------------------
   localparam logic [7:0] POV_SER_PAGE = 8'h40;
   localparam logic [7:0] POV_SER_INDEX = 8'h41;
   localparam logic [7:0] POV_SER_DATA = 8'h42;
   localparam logic [7:0] POV_PAGE_INPUT = 8'h10;
   localparam logic [7:0] POV_OFS_OVERRIDE_CTRL = 8'h47;
   localparam logic [7:0] POV_OFS_FSM_OVERRIDE = 8'h49;
   localparam logic [7:0] POV_OVERRIDE_CTRL_RST = 8'h00;
   localparam logic [7:0] POV_FSM_OVERRIDE_RST = 8'h00;
   localparam logic [7:0] POV_OVERRIDE_CTRL_MASK = 8'ha0;
   localparam logic [7:0] POV_FSM_OVERRIDE_MASK = 8'h1f;
   localparam int POV_BIT_DIV_RST_OVR = 7;
   localparam int POV_BIT_LOCK_FORCE = 5;
   localparam int POV_BIT_FSM_OVR_EN = 4;
   localparam int POV_FSM_STATE_MSB = 3;
   localparam logic [3:0] POV_STATE_RESET = 4'h0;
   localparam logic [3:0] POV_STATE_CLOSED_LOOP_WAIT = 4'h6;
   // ------------------------------------------------------------
   // Init sequence data
   // ------------------------------------------------------------
   localparam logic [7:0] POV_INIT_FSM_DATA = 8'h16;
   localparam logic [7:0] POV_INIT_LOCK_DATA = 8'h20;
   localparam logic [7:0] POV_INIT_RELEASE = 8'h00;
   localparam int POV_INIT_STEPS = 11;
   // ------------------------------------------------------------
   // Host APB register map
   // ------------------------------------------------------------
   localparam logic [7:0] POV_APB_CTRL = 8'h00;
   localparam logic [7:0] POV_APB_STATUS = 8'h04;
   localparam logic [7:0] POV_APB_ACCESS = 8'h08;
   localparam logic [7:0] POV_APB_RDATA = 8'h0c;
   localparam int POV_CTRL_PWRUP = 0;
   localparam int POV_CTRL_START = 1;
   localparam int POV_ACC_WRITE = 16;
   localparam int POV_ACC_GO = 31;
   // Internal PLL controller model timing.
   localparam int POV_LOCK_WAIT_NS = 400;
   localparam int POV_CLK_NS = 4;
   localparam logic [7:0] POV_LOCK_WAIT_CYC = 8'((POV_LOCK_WAIT_NS + POV_CLK_NS - 1) / POV_CLK_NS);
endpackage : pov_pkg

// ---- rtl/pov_pll_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module pov_pll_ctl
   import pov_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic fsm_override_enable,
   input wire logic [3:0] forced_state,
   output logic [3:0] state,
   output logic locked
);
   typedef struct packed {
      logic [3:0] st;
      logic [7:0] cnt;
   } pov_pll_s;
   pov_pll_s s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (!run) begin
         s_d.st = POV_STATE_RESET;
         s_d.cnt = 8'h00;
      end else if (fsm_override_enable) begin
         s_d.st = forced_state;
         s_d.cnt = 8'h00;
      end else if (s_q.st != POV_STATE_CLOSED_LOOP_WAIT) begin
         s_d.st = POV_STATE_CLOSED_LOOP_WAIT;
      end else if (s_q.cnt != POV_LOCK_WAIT_CYC) begin
         s_d.cnt = s_q.cnt + 8'h01;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign state = s_q.st;
   assign locked = !fsm_override_enable && s_q.st == POV_STATE_CLOSED_LOOP_WAIT && s_q.cnt == POV_LOCK_WAIT_CYC;
endmodule : pov_pll_ctl
`default_nettype wire

// ---- tb/pov_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module pov_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic powerdown_n_pin,
   input wire logic req,
   input wire logic wr,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   // ----
   // Link handshake
   // ----
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_take; $rose(req) |=> ack; endproperty
   a_take: assert property (p_take) else $error("ack late");
   property p_pulse; ack |=> !ack; endproperty
   a_pulse: assert property (p_pulse) else $error("ack too long");
   property p_cause; ack |-> req; endproperty
   a_cause: assert property (p_cause) else $error("ack without request");
   property p_hold; req && !ack |=> req && $stable({wr, addr, wdata}); endproperty
   a_hold: assert property (p_hold) else $error("request changed early");
   property p_drop; ack |=> !req; endproperty
   a_drop: assert property (p_drop) else $error("request kept after ack");
   property p_bound; req |-> ##[0:1] ack; endproperty
   a_bound: assert property (p_bound) else $error("no ack in time");
   property p_pin; req |-> powerdown_n_pin; endproperty
   a_pin: assert property (p_pin) else $error("traffic while powered down");
   // Bit 6 is reserved in both override registers, so it never reads back set.
   property p_rsv; ack && !wr && addr == 8'h42 |-> !rdata[6]; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit read set");
endmodule : pov_checker
`default_nettype wire

// ---- tb/pov_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pov_tb;
   import pov_pkg::*;
   localparam logic [15:0] SEQ [11] = '{16'h4010, 16'h4149, 16'h4216, 16'h4147, 16'h4220, 16'h4220,
      16'h4220, 16'h4220, 16'h4200, 16'h4149, 16'h4200};
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rv;
   logic pready, pslverr, dro, lock;
   logic [3:0] st;
   logic [7:0] d;
   logic [64:0] n;
   logic [64:0] q[$];
   logic [15:0] lg[$];
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 10;
   int i;
   pov_if bus();
   always #2 pclk = ~pclk;
   pov_host i_pov_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(bus.host));
   pov_dev i_pov_dev (.pclk(pclk), .presetn(presetn), .link(bus.dev), .divider_reset_override(dro),
      .pll_lock(lock), .pll_state(st));
   pov_checker i_pov_checker (.pclk(pclk), .presetn(presetn), .powerdown_n_pin(bus.powerdown_n_pin),
      .req(bus.req), .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack), .rdata(bus.rdata));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   // ----
   // Watcher
   // ----
   // Every transfer leaves a note, so polls carry a zero mask.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (psel && penable && pready === 1'h1) begin
         n = q.pop_front();
         chk({31'h0, pslverr}, {31'h0, n[64]});
         chk(prdata & n[63:32], n[31:0]);
      end
      // Link writes are logged so the init order can be compared.
      if (bus.ack === 1'h1 && bus.wr === 1'h1) lg.push_back({bus.addr, bus.wdata});
      if (cyc == 5000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv, input logic [31:0] e,
      input logic [31:0] m, input logic er);
      q.push_back({er, m, e & m});
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rv = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dv, input logic [7:0] e);
      int k;
      apb(1'h1, POV_APB_ACCESS, {1'h1, 14'h0, w, a, dv}, '0, '0, 1'h0);
      k = 0;
      do apb(1'h0, POV_APB_STATUS, '0, '0, '0, 1'h0); while (rv[0] !== 1'h0 && ++k < 50);
      chk({31'h0, rv[0]}, 32'h0);
      if (!w) apb(1'h0, POV_APB_RDATA, '0, {24'h0, e}, 32'hff, 1'h0);
   endtask : acc
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, POV_APB_CTRL, '0, '0, 32'h3, 1'h0);
      apb(1'h0, 8'h10, '0, '0, '0, 1'h1);
      chk({30'h0, dro, lock}, '0);
      $display("test reset done");
      apb(1'h1, POV_APB_CTRL, 32'h1, '0, '0, 1'h0);
      // The controller must lock on its own first, so a later forced-low lock is visible.
      repeat (int'(POV_LOCK_WAIT_CYC) + 20) @(posedge pclk);
      chk({31'h0, lock}, 32'h1);
      acc(1'h0, 8'h55, '0, 8'h00);
      acc(1'h1, POV_SER_PAGE, POV_PAGE_INPUT, '0);
      for (i = 0; i < 2; i++) begin
         acc(1'h1, POV_SER_INDEX, i ? POV_OFS_FSM_OVERRIDE : POV_OFS_OVERRIDE_CTRL, '0);
         acc(1'h0, POV_SER_DATA, '0, 8'h00);
         for (int k = 0; k < 3; k++) begin
            d = (k < 2) ? 8'(i ? 16 + 6 * k : 32 << 2 * k) : 8'($random(seed)) & (i ? 8'hff : 8'ha0);
            acc(1'h1, POV_SER_DATA, d, '0);
            acc(1'h0, POV_SER_DATA, '0, d & (i ? 8'h1f : 8'ha0));
            repeat (4) @(posedge pclk);
            if (!i) chk({31'h0, dro}, {31'h0, d[7]});
            if (!i) chk({31'h0, lock}, {31'h0, !d[5]});
            if (i && d[4]) chk({28'h0, st}, {28'h0, d[3:0]});
         end
      end
      $display("test registers done");
      acc(1'h1, POV_SER_DATA, 8'h00, '0);
      acc(1'h1, POV_SER_INDEX, POV_OFS_OVERRIDE_CTRL, '0);
      acc(1'h1, POV_SER_DATA, 8'h00, '0);
      repeat (400) @(posedge pclk);
      chk({31'h0, lock}, 32'h1);
      $display("test release done");
      lg.delete();
      apb(1'h1, POV_APB_CTRL, 32'h3, '0, '0, 1'h0);
      i = 0;
      do apb(1'h0, POV_APB_CTRL, '0, '0, '0, 1'h0); while (rv[1] !== 1'h0 && ++i < 300);
      chk({31'h0, rv[1]}, 32'h0);
      chk(32'(lg.size()), 32'd11);
      for (i = 0; i < 11; i++) chk(32'(lg[i]), 32'(SEQ[i]));
      acc(1'h0, POV_SER_DATA, '0, 8'h00);
      acc(1'h1, POV_SER_INDEX, POV_OFS_OVERRIDE_CTRL, '0);
      acc(1'h0, POV_SER_DATA, '0, 8'h00);
      $display("test sequence done");
      report_and_stop();
   end
endmodule : pov_tb
`default_nettype wire
